// *** rtl/jtp_tap.sv ***
/*
 * Test access port: state machine, instruction register, bypass and
 * identification registers, serial output, and the system-side view
 * of the current instruction and the identification value.
 * Assumes the external controller drives the test clock, mode select,
 * serial input and test reset; the system clock is unrelated.
 */
`default_nettype none

module jtp_tap import jtp_pkg::*; #(
    parameter logic [3:0] ID_REV = ID_REV_DEFAULT
) (
    // system side
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        id_read_req,
    output logic [ID_W-1:0]  id_read_data,
    output logic             id_read_valid,
    output logic [IR_W-1:0]  sys_instr,
    output logic             sys_instr_strobe,
    output logic             sys_tap_in_reset,
    // test pins
    input  wire logic        test_clock_pin,
    input  wire logic        test_reset_low,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdo_oe
);

    // ************************************************************
    // identification value
    // ************************************************************
    logic [ID_W-1:0] id_value;

    assign id_value = {ID_REV, ID_PART, ID_LSB};

    // ************************************************************
    // tap state machine, test clock domain
    // ************************************************************
    jtp_state_t state;
    jtp_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: begin
                next_state = tms ? ST_RESET : ST_IDLE;
            end
            ST_IDLE: begin
                next_state = tms ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_DR: begin
                next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            end
            ST_CAP_DR: begin
                next_state = tms ? ST_EX1_DR : ST_SH_DR;
            end
            ST_SH_DR: begin
                next_state = tms ? ST_EX1_DR : ST_SH_DR;
            end
            ST_EX1_DR: begin
                next_state = tms ? ST_UPD_DR : ST_PAU_DR;
            end
            ST_PAU_DR: begin
                next_state = tms ? ST_EX2_DR : ST_PAU_DR;
            end
            ST_EX2_DR: begin
                next_state = tms ? ST_UPD_DR : ST_SH_DR;
            end
            ST_UPD_DR: begin
                next_state = tms ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_IR: begin
                next_state = tms ? ST_RESET : ST_CAP_IR;
            end
            ST_CAP_IR: begin
                next_state = tms ? ST_EX1_IR : ST_SH_IR;
            end
            ST_SH_IR: begin
                next_state = tms ? ST_EX1_IR : ST_SH_IR;
            end
            ST_EX1_IR: begin
                next_state = tms ? ST_UPD_IR : ST_PAU_IR;
            end
            ST_PAU_IR: begin
                next_state = tms ? ST_EX2_IR : ST_PAU_IR;
            end
            ST_EX2_IR: begin
                next_state = tms ? ST_UPD_IR : ST_SH_IR;
            end
            ST_UPD_IR: begin
                next_state = tms ? ST_SEL_DR : ST_IDLE;
            end
            default: begin
                next_state = ST_RESET;
            end
        endcase
    end

    // test reset acts without the clock
    always_ff @(posedge test_clock_pin or negedge test_reset_low) begin
        if (!test_reset_low) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // instruction register
    // ************************************************************
    logic            cap_ir;
    logic            sh_ir;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] instr;
    logic            upd_toggle;

    assign cap_ir = (state == ST_CAP_IR);
    assign sh_ir  = (state == ST_SH_IR);

    // bit 0 sits next to the serial output, so the lsb moves first
    jtp_shift_reg #(
        .W       (IR_W),
        .RST_VAL (IR_CAPTURE)
    ) u_ir_shift (
        .tck            (test_clock_pin),
        .test_reset_low (test_reset_low),
        .capture        (cap_ir),
        .shift          (sh_ir),
        .cap_val        (IR_CAPTURE),
        .si             (tdi),
        .q              (ir_shift)
    );

    // reserved codes are taken as loaded but select only bypass
    always_ff @(posedge test_clock_pin or negedge test_reset_low) begin
        if (!test_reset_low) begin
            instr <= IR_RESET;
        end else if (state == ST_RESET) begin
            instr <= IR_RESET;
        end else if (state == ST_UPD_IR) begin
            instr <= ir_shift;
        end
    end

    // one flip per update lets the system side see each load
    always_ff @(posedge test_clock_pin or negedge test_reset_low) begin
        if (!test_reset_low) begin
            upd_toggle <= 1'b0;
        end else if (state == ST_UPD_IR) begin
            upd_toggle <= ~upd_toggle;
        end
    end

    // ************************************************************
    // instruction decode and data register selection
    // ************************************************************
    logic sel_id;
    logic sel_bsr;
    logic sel_byp;

    always_comb begin
        sel_id  = 1'b0;
        sel_bsr = 1'b0;
        case (instr)
            INS_IDCODE: begin
                sel_id = 1'b1;
            end
            INS_EXTEST, INS_SAMPLE: begin
                sel_bsr = 1'b1;
            end
            INS_BYPASS: begin
                sel_id = 1'b0;
            end
            default: begin
                sel_id = 1'b0;
            end
        endcase
    end

    // no pin cells exist, so the scan selections fall to bypass
    assign sel_byp = sel_bsr | ~sel_id;

    // ************************************************************
    // data registers
    // ************************************************************
    logic            cap_dr;
    logic            sh_dr;
    logic [ID_W-1:0] id_shift;
    logic            byp_shift;

    assign cap_dr = (state == ST_CAP_DR);
    assign sh_dr  = (state == ST_SH_DR);

    jtp_shift_reg #(
        .W       (ID_W),
        .RST_VAL ('0)
    ) u_id_shift (
        .tck            (test_clock_pin),
        .test_reset_low (test_reset_low),
        .capture        (cap_dr & sel_id),
        .shift          (sh_dr & sel_id),
        .cap_val        (id_value),
        .si             (tdi),
        .q              (id_shift)
    );

    jtp_shift_reg #(
        .W       (1),
        .RST_VAL (BYPASS_CAPTURE)
    ) u_byp_shift (
        .tck            (test_clock_pin),
        .test_reset_low (test_reset_low),
        .capture        (cap_dr & sel_byp),
        .shift          (sh_dr & sel_byp),
        .cap_val        (BYPASS_CAPTURE),
        .si             (tdi),
        .q              (byp_shift)
    );

    // ************************************************************
    // serial output
    // ************************************************************
    logic next_tdo;

    always_comb begin
        if (sh_ir) begin
            next_tdo = ir_shift[0];
        end else if (sel_id) begin
            next_tdo = id_shift[0];
        end else begin
            next_tdo = byp_shift;
        end
    end

    // launched on the falling edge, half a period before the sample
    always_ff @(negedge test_clock_pin or negedge test_reset_low) begin
        if (!test_reset_low) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= next_tdo;
            tdo_oe <= sh_ir | sh_dr;
        end
    end

    // ************************************************************
    // reset-state flag for the system side
    // ************************************************************
    logic in_reset_tck;

    always_ff @(posedge test_clock_pin or negedge test_reset_low) begin
        if (!test_reset_low) begin
            in_reset_tck <= 1'b1;
        end else begin
            in_reset_tck <= (next_state == ST_RESET);
        end
    end

    // ************************************************************
    // crossing into the system clock domain
    // ************************************************************
    logic upd_sync;
    logic upd_seen;
    logic rst_sync;

    jtp_sync #(
        .W (1)
    ) u_upd_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in (upd_toggle),
        .sync_out (upd_sync)
    );

    jtp_sync #(
        .W (1)
    ) u_rst_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in (in_reset_tck),
        .sync_out (rst_sync)
    );

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            upd_seen <= 1'b0;
        end else begin
            upd_seen <= upd_sync;
        end
    end

    // instr stays put for many test clocks after an update, so it is
    // stable by the time the toggle has crossed
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sys_instr <= IR_RESET;
        end else if (upd_sync != upd_seen) begin
            sys_instr <= instr;
        end else if (rst_sync) begin
            sys_instr <= IR_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sys_instr_strobe <= 1'b0;
        end else begin
            sys_instr_strobe <= (upd_sync != upd_seen);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sys_tap_in_reset <= 1'b1;
        end else begin
            sys_tap_in_reset <= rst_sync;
        end
    end

    // ************************************************************
    // processor identification read
    // ************************************************************
    // the value is a constant, so no crossing is needed here
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            id_read_data <= '0;
        end else if (id_read_req) begin
            id_read_data <= id_value;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            id_read_valid <= 1'b0;
        end else begin
            id_read_valid <= id_read_req;
        end
    end

endmodule : jtp_tap

`default_nettype wire

// *** rtl/jtp_pkg.sv ***
/*
 * Constants and types shared by the test access port files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package jtp_pkg;

    // ************************************************************
    // instruction register
    // ************************************************************
    localparam int unsigned IR_W = 5;
    localparam logic [4:0] IR_CAPTURE = 5'h01;
    localparam logic [4:0] INS_EXTEST = 5'h00;
    localparam logic [4:0] INS_IDCODE = 5'h02;
    localparam logic [4:0] INS_SAMPLE = 5'h03;
    localparam logic [4:0] INS_BYPASS = 5'h1F;

    // ************************************************************
    // identification register
    // ************************************************************
    localparam int unsigned ID_W = 32;
    localparam int unsigned ID_REV_W = 4;
    localparam int unsigned ID_PART_W = 27;
    // both values arbitrary, they name no real part or maker
    localparam logic [3:0] ID_REV_DEFAULT = 4'h0;
    localparam logic [26:0] ID_PART = 27'h0A5C3E1;
    localparam logic ID_LSB = 1'b1;

    // ************************************************************
    // bypass, crossing and tap states
    // ************************************************************
    localparam logic BYPASS_CAPTURE = 1'b0;
    localparam logic [4:0] IR_RESET = INS_IDCODE;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jtp_state_t;

endpackage : jtp_pkg

`default_nettype wire

// *** rtl/jtp_sync.sv ***
/*
 * Two-stage level synchroniser into the system clock domain.
 * Assumes the input is quasi-static or a toggle from another clock.
 */
`default_nettype none

module jtp_sync import jtp_pkg::*; #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : jtp_sync

`default_nettype wire

// *** rtl/jtp_shift_reg.sv ***
/*
 * Capture/shift stage of one scan register, shifting toward bit 0.
 * Assumes the test clock and an asynchronous active-low test reset.
 */
`default_nettype none

module jtp_shift_reg import jtp_pkg::*; #(
    parameter int unsigned W         = 1,
    parameter logic [W-1:0] RST_VAL  = '0
) (
    input  wire logic         tck,
    input  wire logic         test_reset_low,
    input  wire logic         capture,
    input  wire logic         shift,
    input  wire logic [W-1:0] cap_val,
    input  wire logic         si,
    output logic      [W-1:0] q
);

    // a one-bit stage has no upper bits, so it gets its own branch
    generate
        if (W == 1) begin : g_one
            always_ff @(posedge tck or negedge test_reset_low) begin
                if (!test_reset_low) begin
                    q <= RST_VAL;
                end else if (capture) begin
                    q <= cap_val;
                end else if (shift) begin
                    q <= si;
                end
            end
        end else begin : g_many
            always_ff @(posedge tck or negedge test_reset_low) begin
                if (!test_reset_low) begin
                    q <= RST_VAL;
                end else if (capture) begin
                    q <= cap_val;
                end else if (shift) begin
                    q <= {si, q[W-1:1]};
                end
            end
        end
    endgenerate

endmodule : jtp_shift_reg

`default_nettype wire

// *** bench/jtp_tap_sva.sv ***
/* Concurrent checks on the test access port's ports.
   Assumes it is bound to jtp_tap and sees only its ports. */
`default_nettype none

module jtp_tap_sva import jtp_pkg::*; #(
    parameter logic [3:0] ID_REV = ID_REV_DEFAULT
) (
    input wire logic            mclk,
    input wire logic            rstn,
    input wire logic            id_read_req,
    input wire logic [ID_W-1:0] id_read_data,
    input wire logic            id_read_valid,
    input wire logic [IR_W-1:0] sys_instr,
    input wire logic            sys_instr_strobe,
    input wire logic            sys_tap_in_reset,
    input wire logic            test_clock_pin,
    input wire logic            test_reset_low,
    input wire logic            tms,
    input wire logic            tdi,
    input wire logic            tdo,
    input wire logic            tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] ID_VAL = {ID_REV, ID_PART, ID_LSB};

    // ********
    // system side
    // ********
    property p_id_ans;
        @(posedge mclk) disable iff (!rstn)
        id_read_req |=> id_read_valid && id_read_data == ID_VAL;
    endproperty
    a_id_ans: assert property (p_id_ans) else $error("id");
    property p_id_cause;
        @(posedge mclk) disable iff (!rstn)
        id_read_valid |-> $past(id_read_req);
    endproperty
    a_id_cause: assert property (p_id_cause) else $error("stray");
    property p_strobe;
        @(posedge mclk) disable iff (!rstn)
        sys_instr_strobe |=> !sys_instr_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("long strobe");
    property p_instr_chg;
        @(posedge mclk) disable iff (!rstn)
        $changed(sys_instr) |-> sys_instr_strobe || sys_instr == INS_IDCODE;
    endproperty
    a_instr_chg: assert property (p_instr_chg) else $error("instr");
    // reset flag and instruction cross separately, so allow a margin
    property p_rst_instr;
        @(posedge mclk) disable iff (!rstn)
        sys_tap_in_reset [*8] |-> sys_instr == INS_IDCODE;
    endproperty
    a_rst_instr: assert property (p_rst_instr) else $error("rst ir");
    property p_trst_pins;
        @(posedge mclk) disable iff (!rstn)
        !test_reset_low |-> !tdo_oe && !tdo;
    endproperty
    a_trst_pins: assert property (p_trst_pins) else $error("trst");
    property p_trst_flag;
        @(posedge mclk) disable iff (!rstn)
        !test_reset_low [*6] |-> sys_tap_in_reset;
    endproperty
    a_trst_flag: assert property (p_trst_flag) else $error("flag");

    // ********
    // test clock side, then covers on both clocks
    // ********
    property p_oe_enter;
        @(posedge test_clock_pin) disable iff (!test_reset_low)
        // entry from capture, or from exit2 after a pause
        $rose(tdo_oe) |-> !$past(tms) && !($past(tms, 2) && $past(tms, 3));
    endproperty
    a_oe_enter: assert property (p_oe_enter) else $error("oe on");
    property p_oe_hold;
        @(posedge test_clock_pin) disable iff (!test_reset_low)
        tdo_oe && !tms |=> tdo_oe;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("oe hold");
    property p_oe_exit;
        @(posedge test_clock_pin) disable iff (!test_reset_low)
        tdo_oe && tms |=> !tdo_oe;
    endproperty
    a_oe_exit: assert property (p_oe_exit) else $error("oe off");

    c_id: cover property (@(posedge mclk) id_read_valid);
    c_strobe: cover property (@(posedge mclk) sys_instr_strobe);
    c_shift: cover property (@(posedge test_clock_pin) $rose(tdo_oe));
endmodule : jtp_tap_sva

`default_nettype wire

// *** bench/jtp_ctl.sv ***
/* Behavioural boundary-scan controller driving the test pins.
   Assumes scans start and end in Run-Test/Idle. */
`default_nettype none

module jtp_ctl (
    output logic     test_clock_pin,
    output logic     test_reset_low,
    output logic     tms,
    output logic     tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;

    // test clock stands still low between frames
    initial begin
        test_clock_pin = 1'b0;
        test_reset_low = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        // a real falling edge, so the async reset cannot miss time zero
        #1;
        test_reset_low = 1'b0;
    end

    // drive after the fall, sample tdo at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80;
        o = tdo;
        test_clock_pin = 1'b1;
        #80;
        test_clock_pin = 1'b0;
    endtask : step

    task automatic trst();
        logic o;
        test_reset_low = 1'b0;
        #320;
        test_reset_low = 1'b1;
        step(1'b0, ~tdi, o);
    endtask : trst

    task automatic tms_reset();
        logic o;
        repeat (5) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask : tms_reset

    // unused tdi cycles toggle so a stale value is never relied on
    task automatic scan(input logic ir, input logic [31:0] din,
                        input int n, output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (ir) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask : scan
endmodule : jtp_ctl

`default_nettype wire

// *** bench/test_jtag_tap_controller.sv ***
/* Self-checking bench for jtp_tap with a controller model.
   Assumes jtp_pkg, jtp_ctl and jtp_tap_sva are compiled first. */
`default_nettype none

module test_jtag_tap_controller import jtp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // arbitrary revision, names no real part
    localparam logic [3:0] ID_REV = 4'h9;
    localparam logic [31:0] ID_VAL = {ID_REV, ID_PART, ID_LSB};

    logic            mclk;
    logic            rstn;
    logic            id_read_req;
    logic [ID_W-1:0] id_read_data;
    logic            id_read_valid;
    logic [IR_W-1:0] sys_instr;
    logic            sys_instr_strobe;
    logic            sys_tap_in_reset;
    logic            test_clock_pin;
    logic            test_reset_low;
    logic            tms;
    logic            tdi;
    logic            tdo;
    logic            tdo_oe;
    int              n_errors = 0;
    int              num_checks = 0;
    logic [31:0]     exp_q[$];
    logic [31:0]     e;
    logic [31:0]     g;
    logic [15:0]     lfsr_st = 16'h38F1;

    jtp_tap #(.ID_REV(ID_REV)) u_dut (
        .mclk(mclk), .rstn(rstn), .id_read_req(id_read_req),
        .id_read_data(id_read_data), .id_read_valid(id_read_valid),
        .sys_instr(sys_instr), .sys_instr_strobe(sys_instr_strobe),
        .sys_tap_in_reset(sys_tap_in_reset),
        .test_clock_pin(test_clock_pin), .test_reset_low(test_reset_low),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    jtp_ctl u_ctl (
        .test_clock_pin(test_clock_pin), .test_reset_low(test_reset_low),
        .tms(tms), .tdi(tdi), .tdo(tdo)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [15:0] rnd();
        lfsr_st = {lfsr_st[14:0],
                   lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic id_rd(input int n);
        repeat (n) begin
            @(posedge mclk) #2 id_read_req = 1'b1;
            exp_q.push_back(ID_VAL);
        end
        @(posedge mclk) #2 id_read_req = 1'b0;
    endtask : id_rd

    // results are taken mid-cycle, clear of the launching edge
    always @(negedge mclk) begin
        if (rstn && (id_read_valid === 1'b1 || sys_instr_strobe === 1'b1)) begin
            e = exp_q.size() ? exp_q.pop_front() : 32'hXXXXXXXX;
            g = id_read_valid ? id_read_data : 32'(sys_instr);
            chk(g, e);
        end
    end

    initial begin
        logic [31:0] d;
        logic [31:0] r;
        logic [4:0]  codes [5];
        rstn = 1'b0;
        id_read_req = 1'b0;
        repeat (20) @(posedge mclk);
        #2 rstn = 1'b1;
        @(negedge mclk) chk(32'(sys_instr), 32'(INS_IDCODE));
        u_ctl.trst();
        u_ctl.scan(1'b0, 32'h0, 32, d);
        chk(d, ID_VAL);
        r = rnd();
        codes = '{INS_IDCODE, INS_EXTEST, INS_SAMPLE,
                  5'h04 | {1'b0, r[3:0]}, INS_BYPASS};
        foreach (codes[k]) begin
            exp_q.push_back(32'(codes[k]));
            u_ctl.scan(1'b1, 32'(codes[k]), IR_W, d);
            chk(d, 32'(IR_CAPTURE));
            r = rnd();
            repeat (8 + r[2:0]) @(posedge mclk);
            id_rd(1 + r[3]);
            r = rnd();
            if (codes[k] == INS_IDCODE) begin
                u_ctl.scan(1'b0, r, 32, d);
                chk(d, ID_VAL);
            end else begin
                u_ctl.scan(1'b0, r, 8, d);
                chk(d, {24'h0, r[6:0], BYPASS_CAPTURE});
            end
        end
        u_ctl.tms_reset();
        repeat (12) @(posedge mclk);
        #2 chk(32'(sys_instr), 32'(INS_IDCODE));
        chk(32'(sys_tap_in_reset), 32'h0);
        exp_q.push_back(32'(INS_BYPASS));
        u_ctl.scan(1'b1, 32'(INS_BYPASS), IR_W, d);
        repeat (12) @(posedge mclk);
        u_ctl.trst();
        repeat (12) @(posedge mclk);
        #2 chk(32'(sys_instr), 32'(INS_IDCODE));
        chk(32'(sys_tap_in_reset), 32'h0);
        u_ctl.scan(1'b0, 32'h0, 32, d);
        chk(d, ID_VAL);
        // every expected update must have shown up as a strobe
        chk(32'(exp_q.size()), 32'h0);
        give_verdict();
    end

    // the full run needs about 42 us
    initial begin
        #150000;
        n_errors++;
        give_verdict();
    end
endmodule : test_jtag_tap_controller

bind jtp_tap jtp_tap_sva #(.ID_REV(ID_REV)) u_sva (
    .mclk(mclk), .rstn(rstn), .id_read_req(id_read_req),
    .id_read_data(id_read_data), .id_read_valid(id_read_valid),
    .sys_instr(sys_instr), .sys_instr_strobe(sys_instr_strobe),
    .sys_tap_in_reset(sys_tap_in_reset),
    .test_clock_pin(test_clock_pin), .test_reset_low(test_reset_low),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
);

`default_nettype wire
